// File: pax_axis.sv
`timescale 1ns/10ps
// Operation
// (R1) Track absolute position from pulse count
// (R2) Software loads absolute position at startup
// (R3) Maximum speed valid from 10 to 200000
// (R4) No pulses unless base below max/10
// (R5) No pulses if speed outside base..max
// (R6) Ramp time word, 50 to 5000 ms
// (R7) Software sets parameters before starting
// (R8) Clear goes to selected or default output
// (R9) Home search uses creep speed register
// (R10) Home search travels at homing speed
// (R11) Read-only envelope stage word
// (R12) Stop flag disables pulse output
// (R13) Busy monitor flag, high while busy
// (R14) Completion interrupt only when enabled
// (R15) Clear output only when clear enabled
// (R16) One clear pulse, 20 ms plus scan
// (R17) Home direction set by direction flag
// (R18) Forward limit flag means limit reached
// (R19) Reverse limit flag means limit reached
// (R20) Near-point polarity flag inverts input
// (R21) Zero-point polarity flag inverts input
// (R22) Homing busy flag high during search
// (R23) Linear ramp base to speed and back
module pax_axis
  import pax_pkg::*;
#(
  parameter int MS_CYC  = MS_CYCLES,
  parameter int CLR_CYC = CLR_CYCLES,
  parameter int N_CLR   = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // Register port
  input  wire pax_bus_s         bus,
  output logic [DW-1:0]         rdata,
  // Homing sensors
  input  wire logic             near_point_in,
  input  wire logic             zero_point_in,
  // Drive outputs
  output logic                  axis_pulse_output,
  output logic                  axis_dir_output,
  output logic                  default_clear_output,
  output logic [N_CLR-1:0]      clear_element_out,
  output logic                  done_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]      acc_reg, pos_reg, max_reg, home_reg, dist_reg, spd_reg;
  logic [15:0]      base_reg, ramp_reg, clrsel_reg, creep_reg, stage_reg;
  logic [8:0]       flag_reg;
  logic             hbusy_reg, err_reg;
  pax_state_e       st_reg;
  pax_mode_e        mode_reg;
  logic             fwd_reg, creep_mode_reg;
  logic [31:0]      cur_reg, tgt_reg, step_reg, rem_reg, accp_reg, phase_reg;
  logic [31:0]      dq_reg, dr_reg;
  logic [5:0]       dcnt_reg;
  logic [31:0]      ms_reg, clr_reg;
  logic             clr_on_reg, pulse_reg, irq_reg;
  logic [N_CLR-1:0] cel_reg;

  // Magnitude of a signed word
  function automatic logic [31:0] mag(input logic [31:0] v);
    mag = v[31] ? 32'(-v) : v;
  endfunction : mag

  // Word decode hit
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] b);
    hit = (a == b);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // Decode and command checks
  wire wr = bus.wr;
  wire [AW-1:0] ad = bus.addr;
  wire [DW-1:0] wd = bus.wdata;
  wire cmd_wr  = wr && hit(ad, A_CMD);
  wire flag_wr = wr && hit(ad, A_FLAGS);
  wire stop    = flag_reg[F_STOP];
  wire idle    = (st_reg == ST_IDLE);
  wire go_move = cmd_wr && wd[C_MOVE] && idle;
  wire go_home = cmd_wr && wd[C_HOME] && !wd[C_MOVE] && idle;
  wire go_rto  = cmd_wr && wd[C_RTO] && !wd[C_MOVE] && !wd[C_HOME]
                 && idle;
  wire go_any  = go_move || go_home || go_rto;

  // Speed for the new command
  wire [31:0] new_spd = go_move ? spd_reg : home_reg;              // R10
  wire [35:0] base_x10 = 36'(base_reg) * 36'(BASE_RATIO);
  wire max_ok  = (max_reg >= MAX_SPD_MIN) && (max_reg <= MAX_SPD_MAX); // R3
  wire base_ok = base_x10 < 36'(max_reg);                          // R4
  wire ramp_ok = (ramp_reg >= RAMP_MIN) && (ramp_reg <= RAMP_MAX); // R6
  wire spd_ok  = (new_spd >= 32'(base_reg)) && (new_spd <= max_reg); // R5
  wire crp_ok  = !go_home || ((32'(creep_reg) >= 32'(base_reg)) &&
                 (32'(creep_reg) <= max_reg));                      // R9
  wire cmd_ok  = max_ok && base_ok && ramp_ok && spd_ok && crp_ok;
  wire start   = go_any && cmd_ok;
  wire refuse  = go_any && !cmd_ok;

  ////////////////////////////////////////////////////////////////////////
  // Homing sensors and limits
  wire near_act = near_point_in ^ flag_reg[F_NINV];                // R20
  wire zero_act = zero_point_in ^ flag_reg[F_ZINV];                // R21
  wire lim_hit  = fwd_reg ? flag_reg[F_FLIM]                       // R18
                          : flag_reg[F_RLIM];                      // R19
  wire homing   = (mode_reg == MD_HOME);

  ////////////////////////////////////////////////////////////////////////
  // Pulse timing
  wire run     = (st_reg == ST_RUN);
  wire live    = run && !stop;                                     // R12
  wire ms_tick = live && (ms_reg == 32'(MS_CYC - 1));
  wire [32:0] ph_sum = 33'(phase_reg) + 33'(cur_reg);
  wire step_now = live && (ph_sum >= 33'(CLK_HZ));
  wire [31:0] ph_next = step_now ? 32'(ph_sum - 33'(CLK_HZ))
                                 : ph_sum[31:0];
  wire dist_mode = !homing;
  wire decel   = dist_mode && (rem_reg <= accp_reg);
  wire accel   = !decel && (cur_reg < tgt_reg);
  wire [31:0] up_v = (tgt_reg - cur_reg > step_reg) ? cur_reg + step_reg
                                                    : tgt_reg;   // R23
  wire [31:0] lo_v = (cur_reg - 32'(base_reg) > step_reg)
                     ? cur_reg - step_reg : 32'(base_reg);       // R23
  wire last_step = dist_mode && step_now && (rem_reg == 32'h00000001);
  wire zero_move = dist_mode && (rem_reg == 32'h00000000);
  wire home_done = homing && creep_mode_reg && zero_act && live;
  wire finish  = run && (last_step || home_done ||
                         (zero_move && !stop));
  wire clr_go  = finish && !dist_mode | (finish &&
                 mode_reg == MD_RTO);

  ////////////////////////////////////////////////////////////////////////
  // Stage word
  wire [15:0] stage_next = !run ? STG_IDLE :
                           (homing && creep_mode_reg) ? STG_CREEP :
                           decel ? STG_DEC :
                           accel ? STG_ACC : STG_CONST;

  ////////////////////////////////////////////////////////////////////////
  // Register readback
  wire [15:0] flag_rd = {4'h0, err_reg, !idle, hbusy_reg, flag_reg[8:0]};
  wire [15:0] rd_next =
      hit(ad, A_ACC_HI)  ? acc_reg[31:16]  :
      hit(ad, A_ACC_LO)  ? acc_reg[15:0]   :
      hit(ad, A_POS_HI)  ? pos_reg[31:16]  :
      hit(ad, A_POS_LO)  ? pos_reg[15:0]   :
      hit(ad, A_MAX_HI)  ? max_reg[31:16]  :
      hit(ad, A_MAX_LO)  ? max_reg[15:0]   :
      hit(ad, A_BASE)    ? base_reg        :
      hit(ad, A_RAMP)    ? ramp_reg        :
      hit(ad, A_CLRSEL)  ? clrsel_reg      :
      hit(ad, A_CREEP)   ? creep_reg       :
      hit(ad, A_HOME_HI) ? home_reg[31:16] :
      hit(ad, A_HOME_LO) ? home_reg[15:0]  :
      hit(ad, A_ENV)     ? stage_reg       :                       // R11
      hit(ad, A_FLAGS)   ? flag_rd         :                       // R13
      hit(ad, A_DIST_HI) ? dist_reg[31:16] :
      hit(ad, A_DIST_LO) ? dist_reg[15:0]  :
      hit(ad, A_SPD_HI)  ? spd_reg[31:16]  :
      hit(ad, A_SPD_LO)  ? spd_reg[15:0]   : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!resetn) rdata <= 16'h0000;
    else if (bus.rd) rdata <= rd_next;
    else rdata <= 16'h0000;
  end

  // Parameter words written by software
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      max_reg    <= 32'h00000000;
      base_reg   <= 16'h0000;
      ramp_reg   <= 16'h0000;
      clrsel_reg <= 16'h0000;
      creep_reg  <= 16'h0000;
      home_reg   <= 32'h00000000;
      dist_reg   <= 32'h00000000;
      spd_reg    <= 32'h00000000;
    end else if (wr) begin                                         // R7
      if (hit(ad, A_MAX_HI))  max_reg[31:16]  <= wd;
      if (hit(ad, A_MAX_LO))  max_reg[15:0]   <= wd;
      if (hit(ad, A_BASE))    base_reg        <= wd;
      if (hit(ad, A_RAMP))    ramp_reg        <= wd;
      if (hit(ad, A_CLRSEL))  clrsel_reg      <= wd;
      if (hit(ad, A_CREEP))   creep_reg       <= wd;
      if (hit(ad, A_HOME_HI)) home_reg[31:16] <= wd;
      if (hit(ad, A_HOME_LO)) home_reg[15:0]  <= wd;
      if (hit(ad, A_DIST_HI)) dist_reg[31:16] <= wd;
      if (hit(ad, A_DIST_LO)) dist_reg[15:0]  <= wd;
      if (hit(ad, A_SPD_HI))  spd_reg[31:16]  <= wd;
      if (hit(ad, A_SPD_LO))  spd_reg[15:0]   <= wd;
    end
  end

  // Control flags, homing busy and error
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      flag_reg  <= 9'h000;
      hbusy_reg <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      if (flag_wr) flag_reg <= wd[8:0];
      if (start && go_home) hbusy_reg <= 1'b1;                     // R22
      else if (finish && homing) hbusy_reg <= 1'b0;                // R22
      else if (flag_wr && !wd[F_HBUSY]) hbusy_reg <= 1'b0;
      if (refuse) err_reg <= 1'b1;
      else if (start) err_reg <= 1'b0;
    end
  end

  // Pulse count and absolute position
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      acc_reg <= 32'h00000000;
      pos_reg <= 32'h00000000;
    end else if (home_done) begin
      acc_reg <= 32'h00000000;
      pos_reg <= 32'h00000000;
    end else if (step_now) begin                                   // R1
      acc_reg <= fwd_reg ? acc_reg + 32'h1 : acc_reg - 32'h1;
      pos_reg <= fwd_reg ? pos_reg + 32'h1 : pos_reg - 32'h1;
    end else if (wr) begin                                         // R2
      if (hit(ad, A_ACC_HI)) acc_reg[31:16] <= wd;
      if (hit(ad, A_ACC_LO)) acc_reg[15:0]  <= wd;
      if (hit(ad, A_POS_HI)) pos_reg[31:16] <= wd;
      if (hit(ad, A_POS_LO)) pos_reg[15:0]  <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: ramp step division, then run
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg   <= ST_IDLE;
      mode_reg <= MD_MOVE;
      fwd_reg  <= 1'b1;
      creep_mode_reg <= 1'b0;
      tgt_reg  <= 32'h0;
      rem_reg  <= 32'h0;
      dq_reg   <= 32'h0;
      dr_reg   <= 32'h0;
      dcnt_reg <= 6'h00;
      step_reg <= 32'h0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (start) begin
            st_reg   <= ST_DIV;
            creep_mode_reg <= 1'b0;
            tgt_reg  <= new_spd;
            dq_reg   <= new_spd - 32'(base_reg);
            dr_reg   <= 32'h0;
            dcnt_reg <= 6'h20;
            if (go_move) begin
              mode_reg <= MD_MOVE;
              fwd_reg  <= !dist_reg[31];
              rem_reg  <= mag(dist_reg);
            end else if (go_home) begin
              mode_reg <= MD_HOME;
              fwd_reg  <= flag_reg[F_HDIR];                        // R17
              rem_reg  <= 32'h0;
            end else begin
              mode_reg <= MD_RTO;
              fwd_reg  <= pos_reg[31];
              rem_reg  <= mag(pos_reg);
            end
          end
        end
        ST_DIV: begin
          // Restoring divide: rise per ms = span / ramp time
          if (dcnt_reg == 6'h00) begin
            st_reg   <= ST_RUN;
            step_reg <= (dq_reg == 32'h0) ? 32'h1 : dq_reg;
          end else begin
            dcnt_reg <= dcnt_reg - 6'h01;
            if ({dr_reg[30:0], dq_reg[31]} >= 32'(ramp_reg)) begin
              dr_reg <= {dr_reg[30:0], dq_reg[31]} - 32'(ramp_reg);
              dq_reg <= {dq_reg[30:0], 1'b1};
            end else begin
              dr_reg <= {dr_reg[30:0], dq_reg[31]};
              dq_reg <= {dq_reg[30:0], 1'b0};
            end
          end
        end
        ST_RUN: begin
          if (finish) st_reg <= ST_IDLE;
          if (step_now && dist_mode) rem_reg <= rem_reg - 32'h1;
          if (homing && live && !creep_mode_reg) begin
            if (near_act) begin
              creep_mode_reg <= 1'b1;
              tgt_reg <= 32'(creep_reg);                           // R9
            end else if (lim_hit) begin
              fwd_reg <= !fwd_reg;                                 // R18
            end
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // Speed profile, phase accumulator and ms timebase
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cur_reg   <= 32'h0;
      accp_reg  <= 32'h0;
      phase_reg <= 32'h0;
      ms_reg    <= 32'h0;
    end else if (!run) begin
      cur_reg   <= 32'(base_reg);                                  // R23
      accp_reg  <= 32'h0;
      phase_reg <= 32'h0;
      ms_reg    <= 32'h0;
    end else if (live) begin
      phase_reg <= ph_next;
      ms_reg <= ms_tick ? 32'h0 : ms_reg + 32'h1;
      if (step_now && accel) accp_reg <= accp_reg + 32'h1;
      if (homing && creep_mode_reg) cur_reg <= tgt_reg;
      else if (ms_tick && decel) cur_reg <= lo_v;                  // R23
      else if (ms_tick && accel) cur_reg <= up_v;                  // R23
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clear pulse at origin arrival
  wire clr_fire = clr_go && flag_reg[F_CLREN] && !clr_on_reg;      // R15
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      clr_on_reg <= 1'b0;
      clr_reg    <= 32'h0;
    end else if (clr_fire) begin
      clr_on_reg <= 1'b1;                                          // R16
      clr_reg    <= 32'(CLR_CYC - 1);
    end else if (clr_on_reg) begin
      if (clr_reg == 32'h0) clr_on_reg <= 1'b0;                    // R16
      else clr_reg <= clr_reg - 32'h1;
    end
  end

  // Clear routing, stage word, drive pins and completion event
  wire sel_ok = clrsel_reg < 16'(N_CLR);
  wire use_sel = flag_reg[F_CLSEL];
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cel_reg   <= '0;
      default_clear_output <= 1'b0;
      stage_reg <= STG_IDLE;
      pulse_reg <= 1'b0;
      axis_dir_output <= 1'b1;
      irq_reg   <= 1'b0;
    end else begin
      cel_reg <= '0;
      if (clr_on_reg && use_sel && sel_ok)
        cel_reg[clrsel_reg[$clog2(N_CLR)-1:0]] <= 1'b1;            // R8
      default_clear_output <= clr_on_reg && !use_sel;              // R8
      stage_reg <= stage_next;                                     // R11
      pulse_reg <= step_now;                                       // R12
      axis_dir_output <= fwd_reg;
      irq_reg <= finish && flag_reg[F_IRQEN];                      // R14
    end
  end

  assign clear_element_out = cel_reg;
  assign axis_pulse_output = pulse_reg;
  assign done_irq = irq_reg;

endmodule : pax_axis

// File: pax_axis_props.sv
`timescale 1ns/10ps
module pax_axis_props
  import pax_pkg::*;
#(
  parameter int CLR_CYC = CLR_CYCLES,
  parameter int N_CLR   = 16
) (
  // Clock and reset
  input wire logic             ref_clk,
  input wire logic             resetn,
  // Register port
  input wire pax_bus_s         bus,
  input wire logic [DW-1:0]    rdata,
  // Homing sensors
  input wire logic             near_point_in,
  input wire logic             zero_point_in,
  // Drive outputs
  input wire logic             axis_pulse_output,
  input wire logic             axis_dir_output,
  input wire logic             default_clear_output,
  input wire logic [N_CLR-1:0] clear_element_out,
  input wire logic             done_irq
);
  logic [DW-1:0] flags_reg;
  logic [31:0]   clr_len_reg;
  logic          any_clr;

  // Any clear line high
  assign any_clr = default_clear_output | (|clear_element_out);

  // Shadow of software flags and clear width count
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      flags_reg   <= '0;
      clr_len_reg <= '0;
    end else begin
      if (bus.wr && bus.addr == A_FLAGS) begin
        flags_reg <= bus.wdata;
      end
      clr_len_reg <= any_clr ? clr_len_reg + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // End of a clear pulse
  sequence clr_end_s;
    $fell(any_clr);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  read_idle_zero_a: assert property (
    !$past(bus.rd) |-> rdata == '0) else $error("rdata not zero");
  stop_no_pulse_a: assert property (
    flags_reg[F_STOP] && $past(flags_reg[F_STOP]) |-> !axis_pulse_output)
    else $error("pulse while stopped");
  irq_needs_en_a: assert property (
    done_irq |-> flags_reg[F_IRQEN]) else $error("irq while disabled");
  irq_one_cycle_a: assert property (
    done_irq |=> !done_irq) else $error("irq longer than one cycle");
  clear_needs_en_a: assert property (
    $rose(any_clr) |-> flags_reg[F_CLREN]) else $error("clear not enabled");
  clear_width_a: assert property (
    clr_end_s |-> clr_len_reg == CLR_CYC) else $error("clear width wrong");
  clear_default_a: assert property (
    default_clear_output |-> !flags_reg[F_CLSEL] && clear_element_out == '0)
    else $error("default clear misrouted");
  clear_select_a: assert property (
    |clear_element_out |-> flags_reg[F_CLSEL] && $onehot(clear_element_out))
    else $error("selected clear misrouted");
endmodule : pax_axis_props

bind pax_axis pax_axis_props #(
  .CLR_CYC(CLR_CYC),
  .N_CLR  (N_CLR)
) pax_axis_props_inst (
  .ref_clk             (ref_clk),
  .resetn              (resetn),
  .bus                 (bus),
  .rdata               (rdata),
  .near_point_in       (near_point_in),
  .zero_point_in       (zero_point_in),
  .axis_pulse_output   (axis_pulse_output),
  .axis_dir_output     (axis_dir_output),
  .default_clear_output(default_clear_output),
  .clear_element_out   (clear_element_out),
  .done_irq            (done_irq)
);

// File: pax_drive_model.sv
`timescale 1ns/10ps
module pax_drive_model #(
  parameter int NEAR_STEPS = 3,
  parameter int ZERO_STEPS = 5
) (
  // Clock and step inputs
  input wire logic ref_clk,
  input wire logic step_in,
  input wire logic dir_in,
  // Bench control
  input wire logic rezero,
  input wire logic invert,
  // Sensor levels
  output logic     near_out,
  output logic     zero_out
);
  int pos = 0;
  int mag;

  // Shaft position from steps and direction
  always @(posedge ref_clk) begin
    if (rezero) begin
      pos <= 0;
    end else if (step_in) begin
      pos <= dir_in ? pos + 1 : pos - 1;
    end
  end

  // Dogs on either side, optionally wired active low
  assign mag      = pos < 0 ? -pos : pos;
  assign near_out = invert ^ (mag >= NEAR_STEPS);
  assign zero_out = invert ^ (mag >= ZERO_STEPS);
endmodule : pax_drive_model

// File: pax_pkg.sv
package pax_pkg;

  // Register port widths
  localparam int AW = 10;
  localparam int DW = 16;

  // Word register addresses
  localparam logic [AW-1:0] A_ACC_HI  = 10'h0a4;
  localparam logic [AW-1:0] A_ACC_LO  = 10'h0a5;
  localparam logic [AW-1:0] A_POS_HI  = 10'h154;
  localparam logic [AW-1:0] A_POS_LO  = 10'h155;
  localparam logic [AW-1:0] A_MAX_HI  = 10'h156;
  localparam logic [AW-1:0] A_MAX_LO  = 10'h157;
  localparam logic [AW-1:0] A_BASE    = 10'h158;
  localparam logic [AW-1:0] A_RAMP    = 10'h159;
  localparam logic [AW-1:0] A_CLRSEL  = 10'h15a;
  localparam logic [AW-1:0] A_CREEP   = 10'h15b;
  localparam logic [AW-1:0] A_HOME_HI = 10'h15c;
  localparam logic [AW-1:0] A_HOME_LO = 10'h15d;
  localparam logic [AW-1:0] A_ENV     = 10'h0fe;
  localparam logic [AW-1:0] A_FLAGS   = 10'h3e0;
  localparam logic [AW-1:0] A_CMD     = 10'h3e1;
  localparam logic [AW-1:0] A_DIST_HI = 10'h3e2;
  localparam logic [AW-1:0] A_DIST_LO = 10'h3e3;
  localparam logic [AW-1:0] A_SPD_HI  = 10'h3e4;
  localparam logic [AW-1:0] A_SPD_LO  = 10'h3e5;

  // Flag word bit positions
  localparam int F_STOP  = 0;
  localparam int F_IRQEN = 1;
  localparam int F_CLREN = 2;
  localparam int F_CLSEL = 3;
  localparam int F_HDIR  = 4;
  localparam int F_FLIM  = 5;
  localparam int F_RLIM  = 6;
  localparam int F_NINV  = 7;
  localparam int F_ZINV  = 8;
  localparam int F_HBUSY = 9;
  localparam int F_BUSY  = 10;
  localparam int F_ERR   = 11;

  // Command word bit positions
  localparam int C_MOVE = 0;
  localparam int C_HOME = 1;
  localparam int C_RTO  = 2;

  // Timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int CLK_NS       = 10;
  localparam int MS_NS        = 1_000_000;
  localparam int CLR_MS       = 20;
  localparam int SCAN_CYCLES  = 1;
  localparam int MS_CYCLES    = MS_NS / CLK_NS;
  localparam int CLR_CYCLES   = CLR_MS * MS_CYCLES + SCAN_CYCLES;

  // Parameter limits
  localparam logic [31:0] MAX_SPD_MIN = 32'h0000000a;
  localparam logic [31:0] MAX_SPD_MAX = 32'h00030d40;
  localparam logic [15:0] RAMP_MIN    = 16'h0032;
  localparam logic [15:0] RAMP_MAX    = 16'h1388;
  localparam logic [3:0]  BASE_RATIO  = 4'ha;

  // Stage codes
  localparam logic [15:0] STG_IDLE  = 16'h0000;
  localparam logic [15:0] STG_ACC   = 16'h0001;
  localparam logic [15:0] STG_CONST = 16'h0002;
  localparam logic [15:0] STG_DEC   = 16'h0003;
  localparam logic [15:0] STG_CREEP = 16'h0004;

  typedef enum {ST_IDLE, ST_DIV, ST_RUN} pax_state_e;
  typedef enum {MD_MOVE, MD_HOME, MD_RTO} pax_mode_e;

  // Register port request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } pax_bus_s;

endpackage : pax_pkg

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
  import pax_pkg::*;
  localparam int MSC = 10;
  localparam int CLC = CLR_MS * MSC + SCAN_CYCLES;
  localparam int BMX[7] = '{9, 200001, 1000, 1000, 1000, 1000, 1000};
  localparam int BB[7]  = '{0, 10, 100, 10, 10, 10, 10};
  localparam int BR[7]  = '{50, 50, 50, 49, 5001, 50, 50};
  localparam int BS[7]  = '{5, 100, 500, 500, 500, 9, 1001};
  logic          ref_clk = 0;
  logic          resetn  = 0;
  pax_bus_s      bus     = '0;
  logic          rezero  = 0;
  logic          invert  = 0;
  logic [DW-1:0] rdata, v, elem_seen;
  logic [31:0]   w;
  logic          near_point_in, zero_point_in, axis_pulse_output;
  logic          axis_dir_output, default_clear_output, done_irq;
  logic [15:0]   clear_element_out;
  int            fails = 0, samples_checked = 0, cyc = 0;
  int            pulses = 0, irqs = 0, dcyc = 0;

  pax_axis #(.MS_CYC(MSC), .CLR_CYC(CLC)) pax_axis_inst (
    .ref_clk(ref_clk), .resetn(resetn), .bus(bus), .rdata(rdata),
    .near_point_in(near_point_in), .zero_point_in(zero_point_in),
    .axis_pulse_output(axis_pulse_output),
    .axis_dir_output(axis_dir_output),
    .default_clear_output(default_clear_output),
    .clear_element_out(clear_element_out), .done_irq(done_irq));
  pax_drive_model pax_drive_model_inst (
    .ref_clk(ref_clk), .step_in(axis_pulse_output),
    .dir_in(axis_dir_output), .rezero(rezero), .invert(invert),
    .near_out(near_point_in), .zero_out(zero_point_in));

  always #5 ref_clk = ~ref_clk;

  // Event counters and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    pulses    += axis_pulse_output;
    irqs      += done_irq;
    dcyc      += default_clear_output;
    elem_seen |= clear_element_out;
    if (cyc == 100000) begin
      fails++;
      summarize;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask : wr
  task rd(input logic [AW-1:0] a);
    @(posedge ref_clk);
    bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1 v = rdata;
  endtask : rd
  task wr32(input logic [AW-1:0] a, input logic [31:0] d);
    wr(a, d[31:16]);
    wr(a + 10'h1, d[15:0]);
  endtask : wr32
  task rd32(input logic [AW-1:0] a);
    rd(a);
    w[31:16] = v;
    rd(a + 10'h1);
    w[15:0] = v;
  endtask : rd32
  task idle;
    int n;
    n = 0;
    do begin
      rd(A_FLAGS);
      n++;
    end while (v[F_BUSY] !== 1'b0 && n < 20000);
    repeat (3) @(posedge ref_clk);
  endtask : idle
  task cfg(input logic [31:0] mx, b, r, sp);
    wr32(A_MAX_HI, mx);
    wr(A_BASE, b[15:0]);
    wr(A_RAMP, r[15:0]);
    wr32(A_SPD_HI, sp);
  endtask : cfg

  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    logic [AW-1:0] a;
    for (int i = 0; i < 12; i++) begin
      a = i < 2 ? A_ACC_HI + 10'(i) : A_POS_HI + 10'(i - 2);
      rd(a);
      chk("reset word", 0, v);
      wr(a, 16'ha5c3 ^ 16'(i));
      rd(a);
      chk("word", 16'ha5c3 ^ 16'(i), v);
    end
    wr(A_ENV, 16'hffff);
    rd(A_ENV);
    chk("stage", STG_IDLE, v);
    rd(10'h3ff);
    chk("unmapped", 0, v);
    rd(A_FLAGS);
    chk("reset flags", 0, v);
    wr(A_FLAGS, 16'h01fe);
    rd(A_FLAGS);
    chk("flags", 16'h01fe, v);
    wr(A_FLAGS, 16'h0000);
    $display("t_regs done");
  endtask : t_regs

  task t_bad;
    for (int i = 0; i < 7; i++) begin
      cfg(BMX[i], BB[i], BR[i], BS[i]);
      wr32(A_DIST_HI, 3);
      pulses = 0;
      wr(A_CMD, 16'h0001);
      repeat (60) @(posedge ref_clk);
      rd(A_FLAGS);
      chk("error", 1, v[F_ERR]);
      chk("pulses", 0, pulses);
    end
    $display("t_bad done");
  endtask : t_bad

  task t_move;
    int n;
    cfg(200000, 19999, 50, 200000);
    wr32(A_POS_HI, 32'h0000fffe);
    wr32(A_ACC_HI, 0);
    wr32(A_DIST_HI, 3);
    wr(A_FLAGS, 16'h0002);
    pulses = 0;
    irqs = 0;
    wr(A_CMD, 16'h0001);
    rd(A_FLAGS);
    chk("busy", 16'h0402, v);
    wr(A_FLAGS, 16'h0003);
    n = pulses;
    repeat (3000) @(posedge ref_clk);
    chk("frozen", n, pulses);
    rd(A_ENV);
    chk("stage", STG_ACC, v);
    wr(A_FLAGS, 16'h0002);
    idle;
    chk("pulses", 3, pulses);
    chk("irq", 1, irqs);
    rd32(A_POS_HI);
    chk("position", 32'h00010001, w);
    rd32(A_ACC_HI);
    chk("count", 3, w);
    wr(A_FLAGS, 16'h0000);
    wr32(A_DIST_HI, 32'hffffffff);
    irqs = 0;
    wr(A_CMD, 16'h0001);
    idle;
    chk("irq off", 0, irqs);
    rd32(A_POS_HI);
    chk("position", 32'h00010000, w);
    $display("t_move done");
  endtask : t_move

  task t_home(input logic [15:0] f, s, input logic inv, d, de,
              input logic [15:0] el);
    int n;
    @(posedge ref_clk);
    invert <= inv;
    rezero <= 1'b1;
    @(posedge ref_clk);
    rezero <= 1'b0;
    wr32(A_HOME_HI, 200000);
    wr(A_CREEP, 16'hc350);
    wr(A_CLRSEL, s);
    wr(A_FLAGS, f);
    pulses = 0;
    dcyc = 0;
    elem_seen = 0;
    wr(A_CMD, 16'h0002);
    rd(A_FLAGS);
    chk("busy", 2'b11, v[F_BUSY:F_HBUSY]);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (axis_pulse_output !== 1'b1 && n < 20000);
    chk("direction", d, axis_dir_output);
    idle;
    repeat (CLC + 5) @(posedge ref_clk);
    rd(A_FLAGS);
    chk("home busy", 0, v[F_HBUSY]);
    chk("steps", 5, pulses);
    rd32(A_POS_HI);
    chk("home pos", 0, w);
    chk("clear len", de * CLC, dcyc);
    chk("clear sel", el, elem_seen);
    $display("t_home done");
  endtask : t_home

  task t_rto;
    wr32(A_POS_HI, 2);
    wr(A_FLAGS, 16'h0004);
    pulses = 0;
    dcyc = 0;
    wr(A_CMD, 16'h0004);
    idle;
    repeat (CLC + 5) @(posedge ref_clk);
    chk("steps", 2, pulses);
    rd32(A_POS_HI);
    chk("origin", 0, w);
    chk("clear len", CLC, dcyc);
    $display("t_rto done");
  endtask : t_rto

  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs;
    t_bad;
    t_move;
    t_home(16'h0014, 0, 0, 1, 1, 16'h0000);
    t_home(16'h01bc, 5, 1, 0, 0, 16'h0020);
    t_home(16'h0010, 0, 0, 1, 0, 16'h0000);
    t_rto;
    summarize;
  end
endmodule : testbench
